// ### logic/shunt_sched_map.svh
// Timing counts and encodings for the single-converter shunt sample scheduler.
// Assumes a 40 MHz timer clock and a 16-bit centre-aligned PWM counter.
`ifndef SHUNT_SCHED_MAP_SVH
`define SHUNT_SCHED_MAP_SVH
`define CLK_MHZ 40
`define CNT_W 16
`define SECTOR_W 3
`define CONV_TIMEOUT_NS 20000
`define CONV_TIMEOUT_CYC ((`CONV_TIMEOUT_NS * `CLK_MHZ + 999) / 1000)
`define PHASE_A 2'h0
`define PHASE_B 2'h1
`define PHASE_C 2'h2
`define CASE_OVF 2'h0
`define CASE_AFTER 2'h1
`define CASE_BEFORE_OFF 2'h2
`define CASE_NONE 2'h3
`endif

// ### logic/shunt_sched_pkg.sv
// Types shared by the shunt sample scheduler modules.
// Assumes shunt_sched_map.svh for widths.
`include "shunt_sched_map.svh"
package shunt_sched_pkg;
   typedef logic [`CNT_W-1:0] count_t;
   typedef logic [1:0] phase_t;
   typedef logic [1:0] timing_case_t;
   typedef enum logic [2:0]
   {
      st_idle = 3'b000,
      st_wait_trig = 3'b001,
      st_conv1 = 3'b010,
      st_gap = 3'b011,
      st_conv2 = 3'b100,
      st_done = 3'b101
   } seq_state_t;
endpackage

// ### logic/sched_cfg_if.sv
// Interface carrying the planned sampling setup from the planner to the sequencer.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface sched_cfg_if;
   import shunt_sched_pkg::*;
   logic load;
   count_t compare_value;
   logic falling_edge;
   phase_t first_phase;
   phase_t second_phase;
   logic no_window;
   modport planner (output load, compare_value, falling_edge, first_phase, second_phase, no_window);
   modport sequencer (input load, compare_value, falling_edge, first_phase, second_phase, no_window);
endinterface

// ### logic/shunt_sample_planner.sv
// Planner: picks phases, timing case and sample compare value from duties and sector.
// Assumes inputs are stable while plan_req is high; one clock domain.
`timescale 1ns/1ps
`include "shunt_sched_map.svh"
module shunt_sample_planner
   import shunt_sched_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control step results
   input wire logic plan_req,
   input wire logic [`SECTOR_W-1:0] sector,
   input wire count_t duty_low_a,
   input wire count_t duty_low_b,
   input wire count_t duty_low_c,
   input wire count_t period_top,
   // Timing settings in counter ticks
   input wire count_t dead_time_interval,
   input wire count_t noise_time,
   input wire count_t rise_time,
   input wire count_t sample_window_time,
   input wire count_t conversion_time,
   // Plan out
   sched_cfg_if.planner cfg,
   output timing_case_t timing_case
);
   // Skipped phase per sector, and the two largest low-side duties kept
   wire skip_a = (sector == 3'h1) || (sector == 3'h6);
   wire skip_b = (sector == 3'h2) || (sector == 3'h3);
   wire [16:0] nr_max = (noise_time > rise_time) ? {1'b0, noise_time} : {1'b0, rise_time};
   wire [17:0] thresh = {1'b0, nr_max} + {2'b00, dead_time_interval};
   wire all_wide = ({2'b00, duty_low_a} > thresh) && ({2'b00, duty_low_b} > thresh)
      && ({2'b00, duty_low_c} > thresh);
   wire phase_t skip_ph = skip_a ? `PHASE_A : (skip_b ? `PHASE_B : `PHASE_C);
   wire phase_t p1 = all_wide ? `PHASE_A : ((skip_ph == `PHASE_A) ? `PHASE_B : `PHASE_A);
   wire phase_t p2 = all_wide ? `PHASE_B : ((skip_ph == `PHASE_C) ? `PHASE_B : `PHASE_C);
   // Minimum duty phase is the skipped one; next one up is its neighbour
   wire count_t d_min = skip_a ? duty_low_a : (skip_b ? duty_low_b : duty_low_c);
   wire count_t d_next = skip_a ? ((duty_low_b < duty_low_c) ? duty_low_b : duty_low_c)
      : (skip_b ? ((duty_low_a < duty_low_c) ? duty_low_a : duty_low_c)
      : ((duty_low_a < duty_low_b) ? duty_low_a : duty_low_b));
   wire [16:0] diff = {1'b0, d_next} - {1'b0, d_min};
   wire [17:0] two_min = {1'b0, d_min, 1'b0};
   wire [17:0] need = {1'b0, sample_window_time, 1'b0} + {2'b00, conversion_time};
   wire min_wide = {2'b00, d_min} > thresh;
   // Timing case selection
   wire timing_case_t case_d = (min_wide || all_wide) ? `CASE_OVF
      : ({1'b0, diff} < two_min) ? `CASE_AFTER
      : ({1'b0, diff} > need) ? `CASE_BEFORE_OFF : `CASE_NONE;
   // Low side on-time is centred: half of it around overflow
   wire [16:0] half_min = {2'b00, d_min[`CNT_W-1:1]};
   wire [17:0] after_pt = {1'b0, period_top} - {1'b0, half_min} + {2'b00, noise_time};
   // Before-off point counts back from the minimum phase's high-side switch-off
   wire [17:0] before_pt = {2'b00, period_top} - {1'b0, half_min} - need;
   wire [17:0] pt_raw = (case_d == `CASE_AFTER) ? after_pt : before_pt;
   wire count_t pt_sat = (pt_raw > {2'b00, period_top}) ? period_top : pt_raw[`CNT_W-1:0];
   wire count_t cmp_d = (case_d == `CASE_OVF) ? period_top : pt_sat;
   // A sampled phase with zero low-side duty cancels the window; only the sector's skip drops a short one
   wire zero_hit = (((p1 == `PHASE_A) || (p2 == `PHASE_A)) && (duty_low_a == 16'h0000))
      || (((p1 == `PHASE_B) || (p2 == `PHASE_B)) && (duty_low_b == 16'h0000))
      || (((p1 == `PHASE_C) || (p2 == `PHASE_C)) && (duty_low_c == 16'h0000));
   logic load_q;
   count_t cmp_q;
   logic fall_q;
   phase_t p1_q;
   phase_t p2_q;
   logic none_q;
   timing_case_t case_q;
   // Register the plan; load pulses one cycle after a request
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         load_q <= 1'b0;
         cmp_q <= 16'h0000;
         fall_q <= 1'b0;
         p1_q <= `PHASE_A;
         p2_q <= `PHASE_B;
         none_q <= 1'b0;
         case_q <= `CASE_OVF;
      end
      else
      begin
         load_q <= plan_req;
         if (plan_req)
         begin
            cmp_q <= cmp_d;
            fall_q <= (case_d == `CASE_AFTER);
            p1_q <= p1;
            p2_q <= p2;
            none_q <= (case_d == `CASE_NONE) || zero_hit;
            case_q <= case_d;
         end
      end
   end
   // Plan leaves through the interface
   assign cfg.load = load_q;
   assign cfg.compare_value = cmp_q;
   assign cfg.falling_edge = fall_q;
   assign cfg.first_phase = p1_q;
   assign cfg.second_phase = p2_q;
   assign cfg.no_window = none_q;
   assign timing_case = case_q;
endmodule // shunt_sample_planner

// ### logic/single_adc_shunt_sample_scheduler.sv
// Top of the single-converter three-shunt sample scheduler.
// Assumes the PWM counter, the converter and the control step share clk.
//
// Summary of operation
// - Convert two phases, third is negative sum
// - Two conversions run in sequence only
// - Fourth PWM compare starts the sequence
// - Before overflow: rising trigger while up-counting
// - After overflow: falling trigger while down-counting
// - Load new compare and channels each step
// - Second start delayed by sample plus conversion
// - Sector chooses the skipped phase
// - All duties wide: always phases A and B
// - Smallest duty selects timing case
// - Short duty, small difference: after overflow
// - Delay start by noise after commutation
// - Else start 2Ts plus Tc before switch-off
// - Assume 2Ts plus Tc below threshold
// - Zero-duty sampled phase: no window; short phase dropped only by sector skip
// - Control step starts when transfer completes
// - Difference too short: no sample this period
`timescale 1ns/1ps
`include "shunt_sched_map.svh"
module single_adc_shunt_sample_scheduler
   import shunt_sched_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // PWM counter
   input wire count_t pwm_count,
   input wire logic pwm_count_up,
   input wire logic pwm_period_start,
   input wire count_t period_top,
   // Control step results
   input wire logic plan_req,
   input wire logic [`SECTOR_W-1:0] sector,
   input wire count_t duty_low_a,
   input wire count_t duty_low_b,
   input wire count_t duty_low_c,
   // Timing settings in counter ticks
   input wire count_t dead_time_interval,
   input wire count_t noise_time,
   input wire count_t rise_time,
   input wire count_t sample_window_time,
   input wire count_t conversion_time,
   // Converter
   output logic adc_start,
   output phase_t adc_channel,
   input wire logic adc_done,
   input wire logic [11:0] adc_result,
   // Fourth channel trigger and results
   output logic sample_trigger,
   output count_t sample_compare_value,
   output logic trigger_falling,
   output logic [12:0] current_a,
   output logic [12:0] current_b,
   output logic [12:0] current_c,
   output logic transfer_done,
   output logic no_sample_flag,
   output timing_case_t timing_case,
   output logic timeout_error
);
   sched_cfg_if cfg ();
   shunt_sample_planner u_planner
   (
      .clk(clk),
      .reset(reset),
      .plan_req(plan_req),
      .sector(sector),
      .duty_low_a(duty_low_a),
      .duty_low_b(duty_low_b),
      .duty_low_c(duty_low_c),
      .period_top(period_top),
      .dead_time_interval(dead_time_interval),
      .noise_time(noise_time),
      .rise_time(rise_time),
      .sample_window_time(sample_window_time),
      .conversion_time(conversion_time),
      .cfg(cfg.planner),
      .timing_case(timing_case)
   );
   // Active plan, swapped in at period start so a mid-period load cannot misfire
   count_t cmp_q;
   logic fall_q;
   phase_t p1_q;
   phase_t p2_q;
   logic none_q;
   logic pend_q;
   count_t pcmp_q;
   logic pfall_q;
   phase_t pp1_q;
   phase_t pp2_q;
   logic pnone_q;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pend_q <= 1'b0;
         pcmp_q <= 16'h0000;
         pfall_q <= 1'b0;
         pp1_q <= `PHASE_A;
         pp2_q <= `PHASE_B;
         pnone_q <= 1'b1;
      end
      else if (cfg.load)
      begin
         pend_q <= 1'b1;
         pcmp_q <= cfg.compare_value;
         pfall_q <= cfg.falling_edge;
         pp1_q <= cfg.first_phase;
         pp2_q <= cfg.second_phase;
         pnone_q <= cfg.no_window;
      end
      else if (pwm_period_start)
      begin
         pend_q <= 1'b0;
      end
   end
   // Swap in at period start; no plan means no window for that period
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cmp_q <= 16'h0000;
         fall_q <= 1'b0;
         p1_q <= `PHASE_A;
         p2_q <= `PHASE_B;
         none_q <= 1'b1;
      end
      else if (pwm_period_start)
      begin
         cmp_q <= pcmp_q;
         fall_q <= pfall_q;
         p1_q <= pp1_q;
         p2_q <= pp2_q;
         none_q <= pnone_q || !pend_q;
      end
   end
   // Compare match, qualified by counting direction
   wire match = (pwm_count == cmp_q);
   wire dir_ok = fall_q ? !pwm_count_up : pwm_count_up;
   wire trig = match && dir_ok;
   logic trig_q;
   always_ff @(posedge clk)
   begin
      if (reset)
         trig_q <= 1'b0;
      else
         trig_q <= trig;
   end
   wire trig_rise = trig && !trig_q;
   // Sequencer: first conversion, gap of sample window plus conversion time, second
   seq_state_t st_q;
   seq_state_t st_d;
   logic [16:0] gap_q;
   logic [15:0] to_q;
   logic [11:0] r1_q;
   wire [16:0] gap_len = {1'b0, sample_window_time} + {1'b0, conversion_time};
   wire gap_end = (gap_q >= gap_len);
   wire to_hit = (to_q == 16'(`CONV_TIMEOUT_CYC));
   wire start_ok = trig_rise && !none_q;
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         st_idle: if (start_ok) st_d = st_conv1;
         st_wait_trig: st_d = st_idle;
         st_conv1: if (adc_done) st_d = st_gap; else if (to_hit) st_d = st_idle;
         st_gap: if (gap_end) st_d = st_conv2;
         st_conv2: if (adc_done) st_d = st_done; else if (to_hit) st_d = st_idle;
         st_done: st_d = st_idle;
         default: st_d = st_idle;
      endcase
   end
   // Gap count runs from the first start so the second starts Ts+Tc later
   always_ff @(posedge clk)
   begin
      if (reset)
         gap_q <= 17'h00000;
      else if (st_q == st_idle)
         gap_q <= 17'h00001;
      else if (gap_q != 17'h1ffff)
         gap_q <= gap_q + 17'h00001;
   end
   always_ff @(posedge clk)
   begin
      if (reset || (st_d != st_q))
         to_q <= 16'h0000;
      else if (!to_hit)
         to_q <= to_q + 16'h0001;
   end
   always_ff @(posedge clk)
   begin
      if (reset)
         st_q <= st_idle;
      else
         st_q <= st_d;
   end
   // Start pulses and channel choice
   wire start1 = (st_q == st_idle) && start_ok;
   wire start2 = (st_q == st_gap) && gap_end;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         adc_start <= 1'b0;
         adc_channel <= `PHASE_A;
      end
      else
      begin
         adc_start <= start1 || start2;
         adc_channel <= start2 ? p2_q : (start1 ? p1_q : adc_channel);
      end
   end
   always_ff @(posedge clk)
   begin
      if (reset)
         r1_q <= 12'h000;
      else if ((st_q == st_conv1) && adc_done)
         r1_q <= adc_result;
   end
   // Rebuild three currents; the skipped one is minus the sum
   wire [12:0] m1 = {1'b0, r1_q};
   wire [12:0] m2 = {1'b0, adc_result};
   wire [12:0] m3 = 13'h0000 - m1 - m2;
   wire fin = (st_q == st_conv2) && adc_done;
   wire [2:0] hit1 = 3'b001 << p1_q;
   wire [2:0] hit2 = 3'b001 << p2_q;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         current_a <= 13'h0000;
         current_b <= 13'h0000;
         current_c <= 13'h0000;
      end
      else if (fin)
      begin
         current_a <= hit1[0] ? m1 : (hit2[0] ? m2 : m3);
         current_b <= hit1[1] ? m1 : (hit2[1] ? m2 : m3);
         current_c <= hit1[2] ? m1 : (hit2[2] ? m2 : m3);
      end
   end
   // Completion strobe lets the control step begin; flags per period
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         transfer_done <= 1'b0;
         no_sample_flag <= 1'b0;
         timeout_error <= 1'b0;
      end
      else
      begin
         transfer_done <= fin;
         no_sample_flag <= pwm_period_start ? (pnone_q || !pend_q) : no_sample_flag;
         timeout_error <= to_hit && ((st_q == st_conv1) || (st_q == st_conv2));
      end
   end
   // Fourth channel mirror; is the user's setting assumption
   assign sample_trigger = trig;
   assign sample_compare_value = cmp_q;
   assign trigger_falling = fall_q;
endmodule // single_adc_shunt_sample_scheduler

// ### verification/shunt_sched_props.sv
// Port-level assertions for the single-converter shunt sample scheduler.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module shunt_sched_props
   import shunt_sched_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Counter and timing
   input wire count_t pwm_count,
   input wire logic pwm_count_up,
   input wire count_t sample_window_time,
   input wire count_t conversion_time,
   // Converter and results
   input wire logic adc_start,
   input wire phase_t adc_channel,
   input wire logic adc_done,
   input wire logic sample_trigger,
   input wire count_t sample_compare_value,
   input wire logic trigger_falling,
   input wire logic [12:0] current_a,
   input wire logic [12:0] current_b,
   input wire logic [12:0] current_c,
   input wire logic transfer_done,
   input wire logic no_sample_flag,
   input wire logic timeout_error
);
   logic [1:0] nstart_q;
   phase_t first_ch_q;
   logic [16:0] gap_q;
   logic conv_q;
   wire first_w = adc_start && nstart_q == 2'h0;
   // Sequence tracking; gap saturates so a long stall cannot wrap
   always_ff @(posedge clk)
   begin
      nstart_q <= (reset || transfer_done || timeout_error) ? 2'h0 : nstart_q + {1'b0, adc_start};
      first_ch_q <= first_w ? adc_channel : first_ch_q;
      gap_q <= first_w ? 17'h1 : (gap_q == 17'h1ffff ? gap_q : gap_q + 17'h1);
      conv_q <= !reset && !timeout_error && (adc_start || (conv_q && !adc_done));
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   start_on_trig_a: assert property ($rose(sample_trigger) && nstart_q == 2'h0 && !no_sample_flag |=> adc_start)
      else $error("trigger did not start a sequence");
   rise_match_a: assert property (sample_trigger && !trigger_falling |-> pwm_count_up && pwm_count == sample_compare_value)
      else $error("rising trigger off its match");
   fall_match_a: assert property (sample_trigger && trigger_falling |-> !pwm_count_up && pwm_count == sample_compare_value)
      else $error("falling trigger off its match");
   conv_gap_a: assert property (adc_start && nstart_q == 2'h1 |-> gap_q >= 17'(sample_window_time + conversion_time))
      else $error("second start too early");
   no_overlap_a: assert property (adc_start |-> !conv_q)
      else $error("start while converter busy");
   other_phase_a: assert property (adc_start && nstart_q == 2'h1 |-> adc_channel != first_ch_q)
      else $error("same phase converted twice");
   done_follow_a: assert property (transfer_done |-> $past(adc_done) && nstart_q == 2'h2)
      else $error("transfer done without second result");
   sum_zero_a: assert property (transfer_done |-> 13'(current_a + current_b + current_c) == 13'h0)
      else $error("currents do not sum to zero");
   no_window_a: assert property (no_sample_flag && nstart_q == 2'h0 |-> !adc_start)
      else $error("start in a period without window");
endmodule // shunt_sched_props

bind single_adc_shunt_sample_scheduler shunt_sched_props u_props (.clk(clk), .reset(reset), .pwm_count(pwm_count),
   .pwm_count_up(pwm_count_up), .sample_window_time(sample_window_time), .conversion_time(conversion_time),
   .adc_start(adc_start), .adc_channel(adc_channel), .adc_done(adc_done), .sample_trigger(sample_trigger),
   .sample_compare_value(sample_compare_value), .trigger_falling(trigger_falling), .current_a(current_a),
   .current_b(current_b), .current_c(current_c), .transfer_done(transfer_done), .no_sample_flag(no_sample_flag),
   .timeout_error(timeout_error));

// ### verification/adc_model.sv
// Behavioural single converter: a start pulse gives a done pulse and result.
// Assumes starts while busy are lost, as on the real part.
`timescale 1ns/1ps
module adc_model
   import shunt_sched_pkg::*;
(
   // Clock
   input wire logic clk,
   // Bench controls
   input wire logic slow,
   input wire logic mute,
   // Converter pins
   input wire logic adc_start,
   input wire phase_t adc_channel,
   output logic adc_done,
   output logic [11:0] adc_result
);
   int cnt = 0;
   logic [11:0] val_q = 12'h0;
   initial adc_done = 1'b0;
   initial adc_result = 12'h0;
   // Data toggles outside done so a stale value is never trusted
   always @(posedge clk)
   begin
      adc_done <= 1'b0;
      adc_result <= ~adc_result;
      if (cnt == 0 && adc_start)
      begin
         cnt <= slow ? 12 : 4;
         val_q <= 12'h100 + 12'(adc_channel) * 12'h055;
      end
      else if (cnt == 1)
      begin
         cnt <= 0;
         adc_done <= !mute;
         adc_result <= val_q;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule // adc_model

// ### verification/single_adc_shunt_sample_scheduler_tb.sv
// Self-checking bench for the shunt sample scheduler with a converter model.
// Assumes a 200-tick centre-aligned counter made here, one tick per clock.
`timescale 1ns/1ps
`include "shunt_sched_map.svh"
module single_adc_shunt_sample_scheduler_tb;
   import shunt_sched_pkg::*;
   logic clk = 1'b0, reset = 1'b1, pwm_count_up = 1'b1, pwm_period_start = 1'b0, plan_req = 1'b0;
   count_t pwm_count = 16'h0, period_top = 16'h00c8, duty_low_a = 16'h0, duty_low_b = 16'h0, duty_low_c = 16'h0;
   logic [`SECTOR_W-1:0] sector = 3'h1;
   count_t dead_time_interval = 16'h0004, noise_time = 16'h0002, rise_time = 16'h0006;
   count_t sample_window_time = 16'h0001, conversion_time = 16'h0003;
   logic adc_start, adc_done, sample_trigger, trigger_falling, transfer_done, no_sample_flag, timeout_error;
   logic slow = 1'b0, mute = 1'b0;
   phase_t adc_channel;
   logic [11:0] adc_result;
   count_t sample_compare_value;
   logic [12:0] current_a, current_b, current_c;
   timing_case_t timing_case;
   int n_errors = 0, checks = 0, cyc = 0;
   single_adc_shunt_sample_scheduler uut (.clk, .reset, .pwm_count, .pwm_count_up, .pwm_period_start, .period_top,
      .plan_req, .sector, .duty_low_a, .duty_low_b, .duty_low_c, .dead_time_interval, .noise_time, .rise_time,
      .sample_window_time, .conversion_time, .adc_start, .adc_channel, .adc_done, .adc_result, .sample_trigger,
      .sample_compare_value, .trigger_falling, .current_a, .current_b, .current_c, .transfer_done, .no_sample_flag,
      .timing_case, .timeout_error);
   adc_model conv (.clk, .slow, .mute, .adc_start, .adc_channel, .adc_done, .adc_result);
   initial forever #12.5 clk = ~clk;
   // Centre-aligned counter; the valley marks period start
   always @(posedge clk)
   begin
      #1;
      if (pwm_count == period_top) pwm_count_up = 1'b0;
      else if (pwm_count == 16'h0) pwm_count_up = 1'b1;
      pwm_count = pwm_count_up ? pwm_count + 16'h1 : pwm_count - 16'h1;
      pwm_period_start = (pwm_count == 16'h0);
   end
   // Hang guard, well above the planned run
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_errors++;
         end_sim();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // Plan mid-period, then watch the period in which it is active
   task automatic run_plan(input logic [2:0] sec, input count_t da, input count_t db, input count_t dc,
      input phase_t skip, input timing_case_t tc, input count_t cmp, input int n_exp, input int win);
      phase_t ch[$];
      int t[$];
      int n_dn;
      int n_to;
      logic flag0;
      logic [12:0] cur[3];
      n_dn = 0;
      n_to = 0;
      do @(posedge clk); while (pwm_count !== 16'h0032);
      #1;
      sector = sec;
      duty_low_a = da;
      duty_low_b = db;
      duty_low_c = dc;
      plan_req = 1'b1;
      @(posedge clk);
      #1 plan_req = 1'b0;
      do @(posedge clk); while (pwm_period_start !== 1'b1);
      for (int i = 0; i < win; i++)
      begin
         @(posedge clk);
         // Registered outputs read after the edge that launches them
         #1;
         if (i == 0) flag0 = no_sample_flag;
         if (adc_start === 1'b1) ch.push_back(adc_channel);
         if (adc_start === 1'b1) t.push_back(i);
         n_dn += int'(transfer_done === 1'b1);
         n_to += int'(timeout_error === 1'b1);
      end
      check("timing_case", 16'(timing_case), 16'(tc));
      check("starts", 16'(ch.size()), 16'(n_exp));
      check("timeouts", 16'(n_to), 16'(n_exp == 1));
      if (n_exp == 0) check("no_sample_flag", 16'(no_sample_flag), 16'h1);
      if (n_exp > 0) check("compare", sample_compare_value, cmp);
      if (tc == `CASE_AFTER) check("falling", 16'(trigger_falling), 16'h1);
      if (tc != `CASE_AFTER) check("rising", 16'(trigger_falling), 16'h0);
      check("window_flag", 16'(flag0), 16'(n_exp == 0));
      if (n_exp == 2 && ch.size() == 2)
      begin
         check("pair", 16'(ch[0] != skip && ch[1] != skip && ch[0] != ch[1]), 16'h1);
         check("gap", 16'(t[1] - t[0] >= 4), 16'h1);
         check("transfer_done", 16'(n_dn), 16'h1);
         check("sum", 16'(13'(current_a + current_b + current_c)), 16'h0);
         cur = '{current_a, current_b, current_c};
         check("first_current", 16'(cur[ch[0]]), 16'h0100 + 16'(ch[0]) * 16'h0055);
         check("second_current", 16'(cur[ch[1]]), 16'h0100 + 16'(ch[1]) * 16'h0055);
      end
   endtask
   // Wide duties: A and B even where the sector would drop A
   task automatic t_common();
      run_plan(3'h1, 16'h0096, 16'h0078, 16'h0064, `PHASE_C, `CASE_OVF, 16'h00c8, 2, 400);
      $display("test common done");
   endtask
   // Each sector with its own phase short, sampled after overflow
   task automatic t_sectors();
      count_t d[3];
      int p;
      for (int s = 1; s <= 6; s++)
      begin
         p = (s == 1 || s == 6) ? 0 : (s <= 3 ? 1 : 2);
         d[p] = 16'h0009;
         d[(p + 1) % 3] = 16'h000c;
         d[(p + 2) % 3] = 16'h0064;
         run_plan(3'(s), d[0], d[1], d[2], 2'(p), `CASE_AFTER, 16'h00c6, 2, 400);
      end
      $display("test sectors done");
   endtask
   // Minimum duty too short, wide difference: start before switch-off
   task automatic t_before_off();
      run_plan(3'h1, 16'h0002, 16'h0014, 16'h0064, `PHASE_A, `CASE_BEFORE_OFF, 16'h00c2, 2, 400);
      $display("test before_off done");
   endtask
   // Zero duties leave no window
   task automatic t_no_window();
      run_plan(3'h1, 16'h0000, 16'h0000, 16'h0064, `PHASE_A, `CASE_NONE, 16'h0, 0, 400);
      $display("test no_window done");
   endtask
   // Slow converter answers; sequence must still pair up
   task automatic t_slow();
      slow = 1'b1;
      run_plan(3'h2, 16'h0096, 16'h0078, 16'h0064, `PHASE_C, `CASE_OVF, 16'h00c8, 2, 400);
      slow = 1'b0;
      $display("test slow done");
   endtask
   // Silent converter: abort once, wider period keeps retriggers clear
   task automatic t_timeout();
      period_top = 16'h00e6;
      mute = 1'b1;
      run_plan(3'h1, 16'h0096, 16'h0078, 16'h0064, `PHASE_C, `CASE_OVF, 16'h00e6, 1, 1100);
      $display("test timeout done");
   endtask
   task automatic end_sim();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      #1 reset = 1'b0;
      t_common();
      t_sectors();
      t_before_off();
      t_no_window();
      t_slow();
      t_timeout();
      end_sim();
   end
endmodule // single_adc_shunt_sample_scheduler_tb
